// >>> svc_ctl.sv
// svc_ctl: controller end, axi4-lite slave that sends address/data pairs and commit pulses
// assumes: one 32-bit word per register; link wires go to the device end
`timescale 1ns/100ps
`default_nettype none
module svc_ctl #(
    parameter int COMMIT_CYC = svc_pkg::COMMIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    svc_if.ctl link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import svc_pkg::*;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_SHIFT = 3'b010,
        CS_COMMIT = 3'b100
    } svc_cstate_e;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        svc_cstate_e st;
        logic [15:0] frame;
        logic [4:0] bitn;
        logic [8:0] half;
        logic [31:0] cnt;
        logic sclk;
        logic sdat;
        logic com;
        logic want_commit;
    } svc_ctl_s;

    svc_ctl_s c_q;
    svc_ctl_s c_d;
    logic busy;

    // ****************************************
    // bus slave and link sequencer
    // ****************************************
    always_comb begin
        c_d = c_q;
        busy = (c_q.st != CS_IDLE);
        if (s_axi_awvalid && !c_q.aw_got) begin
            c_d.aw_got = 1'b1;
            c_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !c_q.w_got) begin
            c_d.w_got = 1'b1;
            c_d.wdata = s_axi_wdata;
            c_d.wstrb = s_axi_wstrb;
        end
        if (c_q.aw_got && c_q.w_got && !c_q.bvalid) begin
            c_d.aw_got = 1'b0;
            c_d.w_got = 1'b0;
            c_d.bvalid = 1'b1;
            c_d.bresp = 2'b00;
            if (c_q.awaddr == HOST_CMD_OFS && c_q.wstrb == 4'hf) begin
                if (busy) begin
                    c_d.bresp = 2'b10;
                end else if (c_q.wdata[HOST_COMMIT_BIT]) begin
                    c_d.st = CS_COMMIT;
                    c_d.cnt = 32'h0;
                    c_d.com = 1'b1;
                end else if (c_q.wdata[HOST_GO_BIT]) begin
                    // address byte then data byte, each lsb first [RL1] [RL16]
                    c_d.frame = {c_q.wdata[7:0], c_q.wdata[15:8]};
                    if (c_q.wdata[15:8] == ADDR_LUMA_DELAY) begin
                        c_d.frame[15:10] = 6'h00; // [RL16]
                    end
                    c_d.st = CS_SHIFT;
                    c_d.bitn = 5'h0;
                    c_d.half = 9'h0;
                end
            end else if (c_q.awaddr != HOST_STATUS_OFS) begin
                c_d.bresp = 2'b10;
            end
        end
        if (c_q.bvalid && s_axi_bready) begin
            c_d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !c_q.rvalid) begin
            c_d.rvalid = 1'b1;
            c_d.rresp = 2'b00;
            c_d.rdata = 32'h0;
            if (s_axi_araddr == HOST_STATUS_OFS) begin
                c_d.rdata = {31'h0, busy};
            end else if (s_axi_araddr != HOST_CMD_OFS) begin
                c_d.rresp = 2'b10;
            end
        end else if (c_q.rvalid && s_axi_rready) begin
            c_d.rvalid = 1'b0;
        end
        unique case (c_q.st)
            CS_IDLE: begin
                c_d.sclk = 1'b1;
            end
            CS_SHIFT: begin
                c_d.half = c_q.half + 9'h1;
                if (c_q.half == 9'(SER_HALF_CYC - 1)) begin
                    c_d.half = 9'h0;
                    if (c_q.sclk) begin
                        c_d.sclk = 1'b0;
                        c_d.sdat = c_q.frame[0];
                    end else begin
                        c_d.sclk = 1'b1;
                        c_d.frame = {1'b0, c_q.frame[15:1]};
                        c_d.bitn = c_q.bitn + 5'h1;
                        if (c_q.bitn == 5'(2 * SER_BITS - 1)) begin
                            c_d.st = CS_IDLE;
                        end
                    end
                end
            end
            CS_COMMIT: begin
                // serial stays idle during the pulse [RL10] [RL2]
                c_d.cnt = c_q.cnt + 32'h1;
                if (c_q.cnt == 32'(COMMIT_CYC - 1)) begin
                    c_d.com = 1'b0;
                    c_d.st = CS_IDLE;
                end
            end
            default: c_d.st = CS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c_q <= '0;
            c_q.st <= CS_IDLE;
            c_q.sclk <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign s_axi_awready = !c_q.aw_got;
    assign s_axi_wready = !c_q.w_got;
    assign s_axi_bvalid = c_q.bvalid;
    assign s_axi_bresp = c_q.bresp;
    assign s_axi_arready = !c_q.rvalid;
    assign s_axi_rvalid = c_q.rvalid;
    assign s_axi_rdata = c_q.rdata;
    assign s_axi_rresp = c_q.rresp;
    assign link.serial_control_clock = c_q.sclk;
    assign link.serial_control_data = c_q.sdat;
    assign link.commit_pulse = c_q.com;
endmodule // svc_ctl
`default_nettype wire

// >>> svc_if.sv
// svc_if: serial link between the config port and its controller
// assumes: the controller drives all three wires
`timescale 1ns/100ps
`default_nettype none
interface svc_if;
    logic serial_control_clock;
    logic serial_control_data;
    logic commit_pulse;
    modport dev (input serial_control_clock, input serial_control_data, input commit_pulse);
    modport ctl (output serial_control_clock, output serial_control_data, output commit_pulse);
endinterface // svc_if
`default_nettype wire

// >>> svc_link_monitor.sv
// svc_link_monitor: timing checks on the serial link between the two ends
// assumes: instantiated beside the link interface, sampled by the system clock
`timescale 1ns/100ps
`default_nettype none
module svc_link_monitor import svc_pkg::*; #(
    parameter int COMMIT_CYC = COMMIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic serial_control_clock,
    input wire logic serial_control_data,
    input wire logic commit_pulse
);
    // ****************************************
    // helper counters
    // ****************************************
    logic [31:0] low_q;
    logic [31:0] hi_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_q <= 32'h0;
            hi_q <= 32'h0;
        end else begin
            low_q <= serial_control_clock ? 32'h0 : low_q + 32'h1;
            hi_q <= commit_pulse ? hi_q + 32'h1 : 32'h0;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence low_hold_s;
        !serial_control_clock [*8];
    endsequence
    sequence high_hold_s;
        serial_control_clock [*8];
    endsequence
    sclk_low_hold_a: assert property (
        $fell(serial_control_clock) |-> low_hold_s) else $error("clock low phase too short");
    sclk_high_hold_a: assert property (
        $rose(serial_control_clock) |-> high_hold_s) else $error("clock high phase too short");
    sclk_rise_due_a: assert property (
        $fell(serial_control_clock) |-> ##[1:120] $rose(serial_control_clock))
        else $error("clock did not rise within the bit");
    half_bit_len_a: assert property (
        $rose(serial_control_clock) |-> low_q inside {[SER_HALF_CYC - 1:SER_HALF_CYC + 1]})
        else $error("clock low phase length wrong");
    data_while_low_a: assert property (
        $changed(serial_control_data) |-> !serial_control_clock)
        else $error("data changed while clock high");
    quiet_commit_a: assert property (
        commit_pulse |-> serial_control_clock) else $error("serial activity during commit");
    commit_len_a: assert property (
        $fell(commit_pulse) |-> hi_q == COMMIT_CYC) else $error("commit pulse length wrong");
endmodule // svc_link_monitor
`default_nettype wire

// >>> svc_pkg.sv
// svc_pkg: constants shared by both ends of the serial video config port
// assumes: a 200 MHz system clock on each end
package svc_pkg;
    // ****************************************
    // register addresses and fields
    // ****************************************
    localparam logic [7:0] ADDR_COMPRESSION = 8'hf0;
    localparam logic [7:0] ADDR_FILTER_OSC = 8'hf1;
    localparam logic [7:0] ADDR_LUMA_DELAY = 8'hf2;
    localparam int CORING_LSB = 0;
    localparam int NOTCH_SEL_BIT = 2;
    localparam int PREFILTER_BIT = 3;
    localparam int NOTCH_PRE_BIT = 4;
    localparam int OSC_EN_BIT = 5;
    localparam int OSC_RES_BIT = 6;
    localparam int WEO_DEL_BIT = 7;
    localparam int LUMA_DELAY_LSB = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LUMA_CLAMP = 8'h10;
    localparam logic [7:0] CHROMA_CLAMP = 8'h80;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int SER_BIT_NS = 1000;
    localparam int SER_HALF_CYC = (SER_BIT_NS / 2) / CLK_PERIOD_NS;
    localparam int SER_BITS = 8;
    localparam logic [3:0] BITS_LAST = 4'h7;
    // commit pulse length in system cycles (2 ms)
    localparam int COMMIT_MS = 2;
    localparam int COMMIT_CYC_DEF = COMMIT_MS * 1000000 / CLK_PERIOD_NS;
    // ****************************************
    // host command register map (axi4-lite)
    // ****************************************
    localparam logic [3:0] HOST_CMD_OFS = 4'h0;
    localparam logic [3:0] HOST_STATUS_OFS = 4'h4;
    localparam int HOST_GO_BIT = 16;
    localparam int HOST_COMMIT_BIT = 17;
endpackage

// >>> svc_port.sv
// svc_port: device end, shifts address/data bytes into line buffers, commits on pulse end
// assumes: link wires asynchronous to clk_i; controller keeps serial quiet around commit
// Notes on behaviour
// RL1: bytes eight bits, lsb first, 1 Mbit/s
// RL2: state undefined until first commit pulse
// RL3: init within one cycle of pulse end
// RL4: init copies line buffers to working registers
// RL5: init leaves on rising serial clock
// RL6: count bits on serial clock rise
// RL7: f0/f1/f2 address picks line buffer
// RL8: eight address bits then data reception
// RL9: store data, clear count, back to address
// RL10: commit pulse aborts reception anytime
// RL11: f0 holds compression value bits 7:0
// RL12: f1 bits 1:0 chroma coring select
// RL13: f1 bit 2 chroma notch select
// RL14: f1 bits 3..5 prefilter, notch, oscillator
// RL15: f1 bit 6 oscillator reset source
// RL16: controller writes zeros to f2 7:2
// RL17: clamp forces luma 16, chroma 128
// RL18: oscillator phase per sample from compression
// RL19: chroma path linear interpolation
// RL20: coring codes off, +1/-1, +1/-0, +2/-1
// RL21: luma delay zero to three cycles
// RL22: unknown address discards following data
// RL23: f1 bit 7 write-enable-out delay select
`timescale 1ns/100ps
`default_nettype none
module svc_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    svc_if.dev link,
    input wire logic clamp_control_i,
    input wire logic [7:0] luma_in_i,
    input wire logic [7:0] chroma_in_i,
    output logic [7:0] compression_value_o,
    output logic [1:0] chroma_coring_select_o,
    output logic chroma_notch_select_o,
    output logic prefilter_enable_o,
    output logic notch_prefilter_enable_o,
    output logic phase_oscillator_enable_o,
    output logic oscillator_reset_source_o,
    output logic write_enable_out_delay_select_o,
    output logic [1:0] luma_delay_o,
    output logic [7:0] phase_o,
    output logic [7:0] luma_out_o,
    output logic [7:0] chroma_out_o
);
    import svc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } svc_state_e;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] sdat_sync;
        logic [2:0] com_sync;
        svc_state_e st;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [1:0] sel;
        logic sel_ok;
        logic [7:0] buf0;
        logic [7:0] buf1;
        logic [7:0] buf2;
        logic [7:0] reg0;
        logic [7:0] reg1;
        logic [7:0] reg2;
        logic [15:0] acc;
        logic [7:0] phase;
        logic [23:0] ydly;
        logic [7:0] luma;
        logic [7:0] chroma_prev;
        logic [7:0] chroma;
    } svc_state_s;

    svc_state_s s_q;
    svc_state_s s_d;

    function automatic logic [7:0] svc_core(input logic [7:0] c, input logic [1:0] mode);
        logic [7:0] r;
        r = c;
        unique case (mode)
            2'b00: r = c;
            2'b01: r = (c == CHROMA_CLAMP + 8'h01 || c == CHROMA_CLAMP - 8'h01) ? CHROMA_CLAMP : c;
            2'b10: r = (c == CHROMA_CLAMP + 8'h01) ? CHROMA_CLAMP : c;
            2'b11: r = (c == CHROMA_CLAMP + 8'h01 || c == CHROMA_CLAMP + 8'h02
                        || c == CHROMA_CLAMP - 8'h01) ? CHROMA_CLAMP : c;
        endcase
        return r;
    endfunction

    logic sclk_rise;
    logic com_fall;
    logic [8:0] chroma_sum;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.sclk_sync = {s_q.sclk_sync[1:0], link.serial_control_clock};
        s_d.sdat_sync = {s_q.sdat_sync[0], link.serial_control_data};
        s_d.com_sync = {s_q.com_sync[1:0], link.commit_pulse};
        sclk_rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2]; // [RL6]
        com_fall = s_q.com_sync[2] & ~s_q.com_sync[1];
        if (s_q.com_sync[1]) begin
            s_d.st = ST_INIT; // [RL10]
            s_d.bits = 4'h0;
        end else if (com_fall) begin
            s_d.st = ST_INIT; // [RL3] [RL2]
            s_d.bits = 4'h0;
            s_d.reg0 = s_q.buf0; // [RL4]
            s_d.reg1 = s_q.buf1;
            s_d.reg2 = s_q.buf2;
        end else if (sclk_rise) begin
            s_d.shift = {s_q.sdat_sync[1], s_q.shift[7:1]}; // [RL1]
            unique case (s_q.st)
                ST_INIT, ST_ADDR: begin
                    // first rising edge in init already carries address bit 0
                    s_d.st = ST_ADDR; // [RL5]
                    s_d.bits = s_q.bits + 4'h1;
                    if (s_q.bits == BITS_LAST) begin
                        s_d.st = ST_DATA; // [RL8]
                        s_d.bits = 4'h0;
                        s_d.sel_ok = 1'b1;
                        unique case (s_d.shift)
                            ADDR_COMPRESSION: s_d.sel = 2'd0; // [RL7]
                            ADDR_FILTER_OSC: s_d.sel = 2'd1;
                            ADDR_LUMA_DELAY: s_d.sel = 2'd2;
                            default: s_d.sel_ok = 1'b0; // [RL22]
                        endcase
                    end
                end
                ST_DATA: begin
                    s_d.bits = s_q.bits + 4'h1;
                    if (s_q.bits == BITS_LAST) begin
                        s_d.st = ST_ADDR; // [RL9]
                        s_d.bits = 4'h0;
                        if (s_q.sel_ok) begin
                            unique case (s_q.sel)
                                2'd0: s_d.buf0 = s_d.shift;
                                2'd1: s_d.buf1 = s_d.shift;
                                default: s_d.buf2 = s_d.shift;
                            endcase
                        end
                    end
                end
                default: s_d.st = ST_INIT;
            endcase
        end
        // phase accumulator: step of value/255 per sample [RL18] [RL11]
        if (s_q.reg1[OSC_EN_BIT]) begin
            s_d.acc = s_q.acc + {8'h00, s_q.reg0};
            if (s_d.acc >= 16'd255) begin
                s_d.acc = s_d.acc - 16'd255;
            end
        end else begin
            s_d.acc = 16'h0000;
        end
        s_d.phase = s_q.acc[7:0];
        // luma delay line [RL21]
        s_d.ydly = {s_q.ydly[15:0], luma_in_i};
        // chroma interpolation midpoint with coring [RL19] [RL20]
        chroma_sum = {1'b0, chroma_in_i} + {1'b0, s_q.chroma_prev};
        s_d.chroma_prev = chroma_in_i;
        if (clamp_control_i) begin
            s_d.luma = LUMA_CLAMP; // [RL17]
            s_d.chroma = CHROMA_CLAMP;
        end else begin
            unique case (s_q.reg2[LUMA_DELAY_LSB +: 2])
                2'd0: s_d.luma = luma_in_i;
                2'd1: s_d.luma = s_q.ydly[7:0];
                2'd2: s_d.luma = s_q.ydly[15:8];
                2'd3: s_d.luma = s_q.ydly[23:16];
            endcase
            s_d.chroma = svc_core(chroma_sum[8:1], s_q.reg1[CORING_LSB +: 2]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.st <= ST_INIT;
            // idle-high serial clock: no false rising edge after reset
            s_q.sclk_sync <= 3'b111;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign compression_value_o = s_q.reg0; // [RL11]
    assign chroma_coring_select_o = s_q.reg1[CORING_LSB +: 2]; // [RL12]
    assign chroma_notch_select_o = s_q.reg1[NOTCH_SEL_BIT]; // [RL13]
    assign prefilter_enable_o = s_q.reg1[PREFILTER_BIT]; // [RL14]
    assign notch_prefilter_enable_o = s_q.reg1[NOTCH_PRE_BIT];
    assign phase_oscillator_enable_o = s_q.reg1[OSC_EN_BIT];
    assign oscillator_reset_source_o = s_q.reg1[OSC_RES_BIT]; // [RL15]
    assign write_enable_out_delay_select_o = s_q.reg1[WEO_DEL_BIT]; // [RL23]
    assign luma_delay_o = s_q.reg2[LUMA_DELAY_LSB +: 2];
    assign phase_o = s_q.phase;
    assign luma_out_o = s_q.luma;
    assign chroma_out_o = s_q.chroma;
endmodule // svc_port
`default_nettype wire

// >>> test_serial_video_config_port.sv
// test_serial_video_config_port: both ends joined by the link, driven over axi4-lite
// assumes: commit pulse shortened to 50 cycles, 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module test_serial_video_config_port;
    import svc_pkg::*;
    localparam int CYC = 50;
    logic clk_i, rst_n_i, clamp_i, sclk_prev;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, coring, ldel;
    logic [7:0] cf, luma_i, chroma_i, luma_o, chroma_o, phase;
    logic notch, pre, npre, osc_en, osc_res, weo_del;
    logic [15:0] cap;
    int nbits = 0;
    int n_errors = 0;
    int cmp_count = 0;
    wire [7:0] f1v = {weo_del, osc_res, osc_en, npre, pre, notch, coring};
    svc_if link();
    svc_port i_svc_port(.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
        .clamp_control_i(clamp_i), .luma_in_i(luma_i), .chroma_in_i(chroma_i),
        .compression_value_o(cf), .chroma_coring_select_o(coring),
        .chroma_notch_select_o(notch), .prefilter_enable_o(pre),
        .notch_prefilter_enable_o(npre), .phase_oscillator_enable_o(osc_en),
        .oscillator_reset_source_o(osc_res), .write_enable_out_delay_select_o(weo_del),
        .luma_delay_o(ldel), .phase_o(phase), .luma_out_o(luma_o), .chroma_out_o(chroma_o));
    svc_ctl #(.COMMIT_CYC(CYC)) i_svc_ctl(.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    svc_link_monitor #(.COMMIT_CYC(CYC)) i_svc_link_monitor(.clk_i(clk_i),
        .rst_n_i(rst_n_i), .serial_control_clock(link.serial_control_clock),
        .serial_control_data(link.serial_control_data), .commit_pulse(link.commit_pulse));
    // ****************************************
    // clock, wire capture, tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        sclk_prev <= link.serial_control_clock;
        if (link.serial_control_clock === 1'b1 && sclk_prev === 1'b0) begin
            cap <= {link.serial_control_data, cap[15:1]};
            nbits <= nbits + 1;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_i);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk_i); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        logic [1:0] r;
        s = 32'h1;
        while (s[0] !== 1'b0) axi_rd(HOST_STATUS_OFS, s, r);
    endtask
    task automatic send(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        int n0;
        n0 = nbits;
        axi_wr(HOST_CMD_OFS, {14'h0, 2'b01, a, d}, r);
        chk("go response", 8'h00, {6'h0, r});
        wait_idle();
        chk("frame bits", 8'h10, 8'(nbits - n0));
        chk("wire address", a, cap[7:0]);
        chk("wire data", d, cap[15:8]);
    endtask
    task automatic commit();
        logic [1:0] r;
        axi_wr(HOST_CMD_OFS, 32'h0002_0000, r);
        wait_idle();
        repeat (6) @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] s;
        logic [1:0] r;
        logic [7:0] v;
        rst_n_i = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, clamp_i} = 6'h0;
        {awaddr, araddr, wdata, luma_i, chroma_i} = '0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        commit();
        send(ADDR_COMPRESSION, 8'hff);
        send(ADDR_FILTER_OSC, 8'ha5);
        send(ADDR_LUMA_DELAY, 8'h03);
        chk("held compression", REG_RESET, cf);
        commit();
        chk("compression", 8'hff, cf);
        chk("f1 fields", 8'ha5, f1v);
        chk("luma delay", 8'h03, {6'h0, ldel});
        $display("test registers done");
        send(ADDR_COMPRESSION, 8'h00);
        send(ADDR_FILTER_OSC, 8'h5a);
        send(ADDR_LUMA_DELAY, 8'h02);
        send(8'hf3, 8'hff);
        send(8'h0f, 8'hff);
        commit();
        chk("compression kept", 8'h00, cf);
        chk("f1 kept", 8'h5a, f1v);
        chk("luma delay kept", 8'h02, {6'h0, ldel});
        $display("test unknown address done");
        axi_rd(4'h8, s, r);
        chk("unmapped read", 8'h02, {6'h0, r});
        axi_rd(HOST_CMD_OFS, s, r);
        chk("command read", 8'h00, s[7:0]);
        axi_wr(4'hc, 32'h0, r);
        chk("unmapped write", 8'h02, {6'h0, r});
        axi_wr(HOST_CMD_OFS, 32'h0001_f0aa, r);
        axi_wr(HOST_CMD_OFS, 32'h0001_f011, r);
        chk("busy write", 8'h02, {6'h0, r});
        wait_idle();
        commit();
        chk("first go kept", 8'haa, cf);
        $display("test host refusals done");
        for (int c = 0; c < 4; c++) begin
            send(ADDR_FILTER_OSC, 8'(c));
            commit();
            for (int k = 0; k < 2; k++) begin
                v = k ? 8'h7f : 8'h81;
                @(posedge clk_i);
                chroma_i <= v;
                repeat (4) @(posedge clk_i);
                chk("cored chroma", (c == 0 || (k && c == 2)) ? v : 8'h80, chroma_o);
            end
        end
        @(posedge clk_i);
        clamp_i <= 1'b1;
        luma_i <= 8'h33;
        chroma_i <= 8'h44;
        repeat (4) @(posedge clk_i);
        chk("clamped luma", LUMA_CLAMP, luma_o);
        chk("clamped chroma", CHROMA_CLAMP, chroma_o);
        clamp_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("released luma", 8'h33, luma_o);
        $display("test coring and clamp done");
        axi_wr(HOST_CMD_OFS, {16'h0001, ADDR_LUMA_DELAY, 8'hff}, r);
        chk("masked go response", 8'h00, {6'h0, r});
        wait_idle();
        chk("f2 unused bits zeroed", 8'h03, cap[15:8]);
        send(ADDR_COMPRESSION, 8'h80);
        send(ADDR_FILTER_OSC, 8'h20);
        commit();
        chk("luma delay masked", 8'h03, {6'h0, ldel});
        @(posedge clk_i);
        v = phase;
        @(posedge clk_i);
        chk("phase step", 8'((32'(v) + 32'h0000_0080) % 32'h0000_00ff), phase);
        $display("test phase oscillator done");
        tally_and_finish();
    end
endmodule // test_serial_video_config_port
`default_nettype wire
